// ==== ioic_pkg.sv ====
// Package for the I/O interrupt control block: register map, fields, timing
package ioic_pkg;

  // ****************************************************************
  // Register map (byte addresses on the Wishbone slave)
  // ****************************************************************
  localparam logic [3:0] CTRL_ADDR = 4'h0; // port control and irq status
  localparam logic [3:0] SEQ_ADDR = 4'h4; // sequencer status and vector
  localparam logic [3:0] CFG_ADDR = 4'h8; // S/C mode bit, same register bit as control word bit 10

  // ****************************************************************
  // Control/status field positions
  // ****************************************************************
  localparam int STAT_LSB = 0;
  localparam int ENA_LSB = 5;
  localparam int SC_BIT = 10;
  localparam int PIS_ACTIVE_BIT = 11;
  localparam int POS_ACTIVE_BIT = 12;
  localparam int WIDTH_LSB = 13;
  localparam int SIF_COPY_BIT = 15;

  // Source index inside the five-bit fields
  localparam int SRC_EXT = 0;
  localparam int SRC_POS = 1;
  localparam int SRC_PIS = 2;
  localparam int SRC_SOE = 3;
  localparam int SRC_SIF = 4;

  // ****************************************************************
  // Reset values and vectors
  // ****************************************************************
  localparam logic [4:0] ENA_RESET = 5'h00;
  localparam logic [4:0] STAT_RESET = 5'h00;
  localparam logic [15:0] HW_VECTOR = 16'h0001;
  localparam logic [15:0] TRAP_VECTOR = 16'h0002;

  // ****************************************************************
  // Timing: CORE_CLK is used as the input clock; T is two of its periods
  // ****************************************************************
  localparam int CORE_PERIOD_PS = 5000;
  localparam int IN_CLK_PERIOD_PS = 5000;
  localparam int T_UNITS = 2;
  localparam int T_CYCLES = (T_UNITS * IN_CLK_PERIOD_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;

  typedef enum logic [1:0] {IOIC_IDLE, IOIC_STROBE} ioic_strobe_state_type;

endpackage

// ==== ioic_top.sv ====
// I/O interrupt control: status flags, masking, vector entry, acknowledge, strobes
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - Five sources: external pin plus serial in, serial out, parallel in, parallel out.
// RULE_02 - Each internal flag sets on its buffer event.
// RULE_03 - Enable field bits 9..5: serial-in, serial-out, par-in, par-out, external; 1 enables.
// RULE_04 - Reset clears all five enable bits.
// RULE_05 - Status bits 4..0 readable, program writes do not change them.
// RULE_06 - Serial-in-full shows in bits 4 and 15; serial data read clears it.
// RULE_07 - Serial-out-empty bit 3 clears on serial data write.
// RULE_08 - Parallel-input-strobe bit 2 clears on read of either parallel port.
// RULE_09 - Parallel-output-strobe bit 1 clears on write of either parallel port.
// RULE_10 - External status bit 0 clears when acknowledge falls at return.
// RULE_11 - Reset clears all five status bits.
// RULE_12 - A set, enabled bit is recognized again after every service routine.
// RULE_13 - Recognition finishes current instruction, then jams branch to address 1.
// RULE_14 - Trap call runs the same entry but targets address 2.
// RULE_15 - No entry during branches or cached loops; request waits.
// RULE_16 - Program counter shadowing is disabled inside a service routine.
// RULE_17 - Requester holds the pin for at least four input-clock periods.
// RULE_18 - Acknowledge rises on recognition and falls on return.
// RULE_19 - While acknowledge is high the external pin is ignored.
// RULE_20 - Bits 12 and 11 make output and input strobes active (1) or passive (0).
// RULE_21 - Bits 14..13 pick active strobe width in units of T.
// RULE_22 - Width codes 00..11 give T, 2T, 3T, 4T.
// RULE_23 - Request to sequencer only when status and enable both set.
module ioic_top (
  input wire logic CORE_CLK, // Core clock, 200 MHz
  input wire logic RST, // Synchronous reset, active high
  input wire logic [3:0] WB_ADR_I, // Wishbone byte address
  input wire logic [31:0] WB_DAT_I, // Wishbone write data
  output logic [31:0] WB_DAT_O, // Wishbone read data
  input wire logic WB_WE_I, // Wishbone write enable
  input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
  input wire logic WB_CYC_I, // Wishbone cycle
  input wire logic WB_STB_I, // Wishbone strobe
  output logic WB_ACK_O, // Wishbone acknowledge
  input wire logic EXT_IRQ, // External interrupt request pin
  output logic SERVICE_ACKNOWLEDGE, // Acknowledge pin, high in service
  input wire logic SERIAL_IN_LOADED, // Pulse: serial input buffer filled
  input wire logic SERIAL_OUT_TAKEN, // Pulse: serial output buffer emptied
  input wire logic SERIAL_DATA_READ, // Pulse: program read serial buffer
  input wire logic SERIAL_DATA_WRITE, // Pulse: program wrote serial buffer
  input wire logic PAR_IN_WRITTEN, // Pulse: parallel input register written
  input wire logic PAR_OUT_READ, // Pulse: parallel output buffer read
  input wire logic PAR_PORT_A_READ, // Pulse: program read parallel port a
  input wire logic PAR_PORT_B_READ, // Pulse: program read parallel port b
  input wire logic PAR_PORT_A_WRITE, // Pulse: program wrote parallel port a
  input wire logic PAR_PORT_B_WRITE, // Pulse: program wrote parallel port b
  input wire logic INSTR_BOUNDARY, // Pulse: current instruction completes
  input wire logic INSTR_UNINTERRUPTIBLE, // Branch or cached instruction ends
  input wire logic TRAP_CALL, // Trap-call instruction completes
  input wire logic RETURN_EXEC, // Return-from-interrupt executes
  output logic JAM_BRANCH, // Pulse: insert branch into instr reg
  output logic [15:0] JAM_TARGET, // Branch target of the jammed branch
  output logic PC_SHADOW_EN, // Program counter shadow enable
  output logic IRQ_PENDING, // Any enabled status bit set
  output logic PAR_OUT_STROBE_O, // Parallel output strobe drive
  output logic PAR_OUT_STROBE_OE, // High while driving output strobe
  output logic PAR_IN_STROBE_O, // Parallel input strobe drive
  output logic PAR_IN_STROBE_OE // High while driving input strobe
);
  import ioic_pkg::*;

  typedef struct packed {
    logic [4:0] ena;
    logic [4:0] stat;
    logic sc_mode;
    logic pis_active;
    logic pos_active;
    logic [1:0] width;
    logic in_service;
    logic jam;
    logic [15:0] target;
    logic ack;
    logic [31:0] rdata;
    logic pos_run;
    logic pis_run;
    logic [3:0] pos_cnt;
    logic [3:0] pis_cnt;
  } ioic_state_type;

  ioic_state_type r;
  ioic_state_type next_r;

  // Strobe length in core cycles for a width code
  function automatic logic [3:0] strobe_len(input logic [1:0] code);
    strobe_len = 4'((int'(code) + 1) * T_CYCLES); // RULE_22
  endfunction

  // Assemble the control/status word as software sees it
  function automatic logic [15:0] ctrl_word(input ioic_state_type s);
    logic [15:0] w;
    w = 16'h0000;
    w[STAT_LSB +: 5] = s.stat; // RULE_05
    w[ENA_LSB +: 5] = s.ena;
    w[SC_BIT] = s.sc_mode;
    w[PIS_ACTIVE_BIT] = s.pis_active;
    w[POS_ACTIVE_BIT] = s.pos_active;
    w[WIDTH_LSB +: 2] = s.width;
    w[SIF_COPY_BIT] = s.stat[SRC_SIF]; // RULE_06
    return w;
  endfunction

  logic bus_req;
  logic wr_ctrl;
  logic [4:0] pending;
  logic take;
  logic [15:0] ctrl_view;
  // Software view of the control word, also watched by the checks
  assign ctrl_view = ctrl_word(r);
  assign bus_req = WB_CYC_I && WB_STB_I && !r.ack;
  assign wr_ctrl = bus_req && WB_WE_I && (WB_ADR_I == CTRL_ADDR);
  // Enabled requests only reach the sequencer
  assign pending = r.stat & r.ena; // RULE_23 RULE_01
  // Hold off across uninterruptible instructions and while already serving
  assign take = INSTR_BOUNDARY && !INSTR_UNINTERRUPTIBLE && !r.in_service; // RULE_15

  always_comb begin
    next_r = r;
    next_r.jam = 1'b0;
    next_r.ack = bus_req;
    // Internal flags: set beats a simultaneous clear
    if (SERIAL_DATA_READ) begin
      next_r.stat[SRC_SIF] = 1'b0; // RULE_06
    end
    if (SERIAL_DATA_WRITE) begin
      next_r.stat[SRC_SOE] = 1'b0; // RULE_07
    end
    if (PAR_PORT_A_READ || PAR_PORT_B_READ) begin
      next_r.stat[SRC_PIS] = 1'b0; // RULE_08
    end
    if (PAR_PORT_A_WRITE || PAR_PORT_B_WRITE) begin
      next_r.stat[SRC_POS] = 1'b0; // RULE_09
    end
    if (SERIAL_IN_LOADED) begin
      next_r.stat[SRC_SIF] = 1'b1; // RULE_02
    end
    if (SERIAL_OUT_TAKEN) begin
      next_r.stat[SRC_SOE] = 1'b1; // RULE_02
    end
    if (PAR_IN_WRITTEN) begin
      next_r.stat[SRC_PIS] = 1'b1; // RULE_02
    end
    if (PAR_OUT_READ) begin
      next_r.stat[SRC_POS] = 1'b1; // RULE_02
    end
    // Return ends service; falling acknowledge clears the external flag
    if (RETURN_EXEC && r.in_service) begin
      next_r.in_service = 1'b0; // RULE_18
      next_r.stat[SRC_EXT] = 1'b0; // RULE_10
    end
    // Pin sampled only while acknowledge is low
    if (EXT_IRQ && !r.in_service) begin
      next_r.stat[SRC_EXT] = 1'b1; // RULE_19
    end
    // Entry: hardware request to 1, trap call to 2; flags stay set so
    // a still-pending source re-enters after return
    if (take && (|pending)) begin
      next_r.in_service = 1'b1; // RULE_13 RULE_12
      next_r.jam = 1'b1;
      next_r.target = HW_VECTOR;
    end else if (take && TRAP_CALL) begin
      next_r.in_service = 1'b1; // RULE_14
      next_r.jam = 1'b1;
      next_r.target = TRAP_VECTOR;
    end
    // Register writes: status bits are never written
    if (wr_ctrl && WB_SEL_I[0]) begin
      next_r.ena[2:0] = WB_DAT_I[7:5]; // RULE_03
    end
    if (wr_ctrl && WB_SEL_I[1]) begin
      next_r.ena[4:3] = WB_DAT_I[9:8]; // RULE_03
      next_r.sc_mode = WB_DAT_I[SC_BIT];
      next_r.pis_active = WB_DAT_I[PIS_ACTIVE_BIT]; // RULE_20
      next_r.pos_active = WB_DAT_I[POS_ACTIVE_BIT]; // RULE_20
      next_r.width = WB_DAT_I[WIDTH_LSB +: 2]; // RULE_21
    end
    if (bus_req && WB_WE_I && (WB_ADR_I == CFG_ADDR) && WB_SEL_I[0]) begin
      next_r.sc_mode = WB_DAT_I[0];
    end
    // Read mux; unmapped reads return zero
    next_r.rdata = 32'h00000000;
    if (bus_req && !WB_WE_I) begin
      case (WB_ADR_I)
        CTRL_ADDR: next_r.rdata = {16'h0000, ctrl_word(r)};
        SEQ_ADDR: next_r.rdata = {r.target, 13'h0000, r.in_service, |pending, r.jam};
        CFG_ADDR: next_r.rdata = {31'h00000000, r.sc_mode};
        default: next_r.rdata = 32'h00000000;
      endcase
    end
    // Active strobes: pulse for the programmed width on each port access
    // An access during a running pulse does not restart it, so back-to-back
    // port accesses closer than the width share one strobe
    if (r.pos_run) begin
      next_r.pos_cnt = r.pos_cnt - 4'h1;
      next_r.pos_run = (r.pos_cnt != 4'h1);
    end else if (r.pos_active && (PAR_PORT_A_WRITE || PAR_PORT_B_WRITE)) begin
      next_r.pos_run = 1'b1; // RULE_21
      next_r.pos_cnt = strobe_len(r.width);
    end
    if (r.pis_run) begin
      next_r.pis_cnt = r.pis_cnt - 4'h1;
      next_r.pis_run = (r.pis_cnt != 4'h1);
    end else if (r.pis_active && (PAR_PORT_A_READ || PAR_PORT_B_READ)) begin
      next_r.pis_run = 1'b1; // RULE_21
      next_r.pis_cnt = strobe_len(r.width);
    end
  end

  // State register with synchronous reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      r <= '0;
      r.ena <= ENA_RESET; // RULE_04
      r.stat <= STAT_RESET; // RULE_11
    end else begin
      r <= next_r;
    end
  end

  // Outputs, all from flip-flops except the pending summary
  assign WB_DAT_O = r.rdata;
  assign WB_ACK_O = r.ack;
  assign SERVICE_ACKNOWLEDGE = r.in_service; // RULE_18
  assign JAM_BRANCH = r.jam;
  assign JAM_TARGET = r.target;
  assign PC_SHADOW_EN = !r.in_service; // RULE_16
  assign IRQ_PENDING = |pending;
  assign PAR_OUT_STROBE_O = r.pos_run;
  assign PAR_OUT_STROBE_OE = r.pos_active; // RULE_20
  assign PAR_IN_STROBE_O = r.pis_run;
  assign PAR_IN_STROBE_OE = r.pis_active; // RULE_20

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_RESET_ENA: assert property (@(posedge CORE_CLK) $past(RST) |-> r.ena == 5'h00) // RULE_04
    else $error("enables not cleared by reset");
  AST_RESET_STAT: assert property (@(posedge CORE_CLK) $past(RST) |-> r.stat == 5'h00) // RULE_11
    else $error("status not cleared by reset");
  AST_STAT_NOWRITE: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr_ctrl && !SERIAL_IN_LOADED && !SERIAL_OUT_TAKEN && !PAR_IN_WRITTEN && !PAR_OUT_READ
    && !EXT_IRQ && !RETURN_EXEC && !SERIAL_DATA_READ && !SERIAL_DATA_WRITE
    && !PAR_PORT_A_READ && !PAR_PORT_B_READ && !PAR_PORT_A_WRITE && !PAR_PORT_B_WRITE
    |=> $stable(r.stat)) // RULE_05
    else $error("status changed by a program write");
  AST_SIF_SET: assert property (@(posedge CORE_CLK) disable iff (RST)
    SERIAL_IN_LOADED |=> r.stat[SRC_SIF] && ctrl_view[SIF_COPY_BIT]) // RULE_02
    else $error("serial in flag not set");
  AST_SIF_CLR: assert property (@(posedge CORE_CLK) disable iff (RST)
    SERIAL_DATA_READ && !SERIAL_IN_LOADED |=> !r.stat[SRC_SIF]) // RULE_06
    else $error("serial in flag not cleared");
  AST_SOE_CLR: assert property (@(posedge CORE_CLK) disable iff (RST)
    SERIAL_DATA_WRITE && !SERIAL_OUT_TAKEN |=> !r.stat[SRC_SOE]) // RULE_07
    else $error("serial out flag not cleared");
  AST_PIS_CLR: assert property (@(posedge CORE_CLK) disable iff (RST)
    PAR_PORT_B_READ && !PAR_IN_WRITTEN |=> !r.stat[SRC_PIS]) // RULE_08
    else $error("parallel in flag not cleared");
  AST_POS_CLR: assert property (@(posedge CORE_CLK) disable iff (RST)
    PAR_PORT_B_WRITE && !PAR_OUT_READ |=> !r.stat[SRC_POS]) // RULE_09
    else $error("parallel out flag not cleared");
  AST_EXT_CLR: assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(SERVICE_ACKNOWLEDGE) |-> !r.stat[SRC_EXT]) // RULE_10
    else $error("external flag survives acknowledge fall");
  AST_ENTRY: assert property (@(posedge CORE_CLK) disable iff (RST)
    take && (|pending) |=> JAM_BRANCH && JAM_TARGET == 16'h0001 && SERVICE_ACKNOWLEDGE) // RULE_13
    else $error("hardware entry wrong");
  AST_TRAP: assert property (@(posedge CORE_CLK) disable iff (RST)
    take && !(|pending) && TRAP_CALL |=> JAM_BRANCH && JAM_TARGET == 16'h0002) // RULE_14
    else $error("trap entry wrong");
  AST_NO_ENTRY: assert property (@(posedge CORE_CLK) disable iff (RST)
    INSTR_UNINTERRUPTIBLE |=> !JAM_BRANCH) // RULE_15
    else $error("entry during uninterruptible instruction");
  AST_SHADOW: assert property (@(posedge CORE_CLK) disable iff (RST)
    SERVICE_ACKNOWLEDGE |-> !PC_SHADOW_EN) // RULE_16
    else $error("shadow enabled in service");
  AST_RET: assert property (@(posedge CORE_CLK) disable iff (RST)
    SERVICE_ACKNOWLEDGE && RETURN_EXEC |=> !SERVICE_ACKNOWLEDGE) // RULE_18
    else $error("acknowledge not dropped on return");
  AST_PIN_MASK: assert property (@(posedge CORE_CLK) disable iff (RST)
    SERVICE_ACKNOWLEDGE && !RETURN_EXEC && !r.stat[SRC_EXT] |=> !r.stat[SRC_EXT]) // RULE_19
    else $error("pin sampled while acknowledged");
  AST_PEND: assert property (@(posedge CORE_CLK) disable iff (RST)
    IRQ_PENDING |-> |(r.stat & r.ena)) // RULE_23
    else $error("pending without enabled status");
  AST_WIDTH: assert property (@(posedge CORE_CLK) disable iff (RST)
    !r.pos_run && r.pos_active && r.width == 2'b00 && PAR_PORT_A_WRITE
    |=> PAR_OUT_STROBE_O [*2] ##1 !PAR_OUT_STROBE_O) // RULE_22
    else $error("strobe width T wrong");

  // ****************************************************************
  // Source, mapping, entry and bus checks
  // ****************************************************************
  // Clears from the other parallel port
  AST_PIS_CLR_A: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_08
    PAR_PORT_A_READ && !PAR_IN_WRITTEN |=> !r.stat[SRC_PIS])
    else $error("parallel in flag not cleared by port a");
  AST_POS_CLR_A: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_09
    PAR_PORT_A_WRITE && !PAR_OUT_READ |=> !r.stat[SRC_POS])
    else $error("parallel out flag not cleared by port a");

  // Set events and per-source requests
  AST_SOE_SET: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_02
    SERIAL_OUT_TAKEN |=> r.stat[SRC_SOE])
    else $error("serial out flag not set");
  AST_PIS_SET: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_02
    PAR_IN_WRITTEN |=> r.stat[SRC_PIS])
    else $error("parallel in flag not set");
  AST_POS_SET: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_02
    PAR_OUT_READ |=> r.stat[SRC_POS])
    else $error("parallel out flag not set");
  AST_SRC_SIF: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_01
    SERIAL_IN_LOADED && r.ena[SRC_SIF] && !wr_ctrl |=> IRQ_PENDING)
    else $error("serial in source raises no request");
  AST_SRC_EXT: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_01
    EXT_IRQ && !SERVICE_ACKNOWLEDGE && r.ena[SRC_EXT] && !wr_ctrl |=> IRQ_PENDING)
    else $error("external source raises no request");

  // Register field mapping
  AST_ENA_MAP: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_03
    wr_ctrl && WB_SEL_I == 4'h3 |=> r.ena == $past(WB_DAT_I[9:5]))
    else $error("enable field mapped wrong");
  AST_MODE_MAP: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_20
    wr_ctrl && WB_SEL_I[1] |=> PAR_OUT_STROBE_OE == $past(WB_DAT_I[12])
    && PAR_IN_STROBE_OE == $past(WB_DAT_I[11]))
    else $error("strobe mode bits mapped wrong");

  // Entry, re-entry and reset outputs
  AST_REENTRY: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_12
    SERVICE_ACKNOWLEDGE && RETURN_EXEC && r.stat[SRC_SIF] && r.ena[SRC_SIF]
    && !SERIAL_DATA_READ && !wr_ctrl |=> IRQ_PENDING && !SERVICE_ACKNOWLEDGE)
    else $error("set enabled flag not pending after return");
  AST_JAM_PULSE: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_13
    JAM_BRANCH |=> !JAM_BRANCH)
    else $error("jammed branch longer than one cycle");
  AST_TRAP_ACK: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_14
    take && !(|pending) && TRAP_CALL |=> SERVICE_ACKNOWLEDGE && !PC_SHADOW_EN)
    else $error("trap entry does not enter service");
  AST_RESET_OUT: assert property (@(posedge CORE_CLK) // RULE_18
    $past(RST) |-> !SERVICE_ACKNOWLEDGE && PC_SHADOW_EN && !JAM_BRANCH)
    else $error("service outputs not idle after reset");

  // Bus answer timing
  AST_BUS_ACK: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_05
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acknowledged");
  AST_BUS_DROP: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_05
    WB_ACK_O |=> !WB_ACK_O)
    else $error("bus acknowledge longer than one cycle");

  // ****************************************************************
  // Strobe width checks
  // ****************************************************************
  // Output strobe, codes 01 to 11 give 2T to 4T
  AST_POS_W2: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_22
    $rose(PAR_OUT_STROBE_O) && r.width == 2'b01 |-> PAR_OUT_STROBE_O [*4] ##1 !PAR_OUT_STROBE_O)
    else $error("output strobe width 2T wrong");
  AST_POS_W3: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_22
    $rose(PAR_OUT_STROBE_O) && r.width == 2'b10 |-> PAR_OUT_STROBE_O [*6] ##1 !PAR_OUT_STROBE_O)
    else $error("output strobe width 3T wrong");
  AST_POS_W4: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_22
    $rose(PAR_OUT_STROBE_O) && r.width == 2'b11 |-> PAR_OUT_STROBE_O [*8] ##1 !PAR_OUT_STROBE_O)
    else $error("output strobe width 4T wrong");
  // Input strobe, all four codes
  AST_PIS_W1: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_21
    $rose(PAR_IN_STROBE_O) && r.width == 2'b00 |-> PAR_IN_STROBE_O [*2] ##1 !PAR_IN_STROBE_O)
    else $error("input strobe width T wrong");
  AST_PIS_W2: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_21
    $rose(PAR_IN_STROBE_O) && r.width == 2'b01 |-> PAR_IN_STROBE_O [*4] ##1 !PAR_IN_STROBE_O)
    else $error("input strobe width 2T wrong");
  AST_PIS_W3: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_21
    $rose(PAR_IN_STROBE_O) && r.width == 2'b10 |-> PAR_IN_STROBE_O [*6] ##1 !PAR_IN_STROBE_O)
    else $error("input strobe width 3T wrong");
  AST_PIS_W4: assert property (@(posedge CORE_CLK) disable iff (RST) // RULE_21
    $rose(PAR_IN_STROBE_O) && r.width == 2'b11 |-> PAR_IN_STROBE_O [*8] ##1 !PAR_IN_STROBE_O)
    else $error("input strobe width 4T wrong");

endmodule

// ==== ioic_ext_req.sv ====
// External requester model driving the interrupt request pin
`timescale 1ns/1ps
// ****************************************
// External requester
// ****************************************
module ioic_ext_req (
  input wire logic clk, // Core clock
  input wire logic rst, // Sync reset, active high
  input wire logic go, // Pulse: start one request
  input wire logic [3:0] hold_len, // Cycles the pin is held
  output logic irq // Request pin, idle low
);
  logic [3:0] left;
  // Hold time count; a short hold is only ever the caller's choice
  always_ff @(posedge clk) begin
    if (rst) begin
      left <= 4'h0;
    end else if (go) begin
      left <= hold_len;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  assign irq = (left != 4'h0);
endmodule

// ==== testbench.sv ====
// Self-checking bench for the I/O interrupt control block
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h exp %h", $time, a, e); end end
module testbench;
  import ioic_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic ack, svc_ack, jam, shadow, pend, pos_o, pos_oe, pis_o, pis_oe, ext_irq;
  logic [15:0] target;
  logic [12:0] ev = 13'h0;
  logic trap = 1'b0;
  logic unint = 1'b0;
  logic [3:0] hold = 4'h4;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  int set_ev[6] = '{0, 2, 4, 6, 4, 6};
  int clr_ev[6] = '{1, 3, 5, 7, 8, 9};
  logic [15:0] exp_v[6] = '{16'h8010, 16'h0008, 16'h0004, 16'h0002, 16'h0004, 16'h0002};
  // ****************************************
  // Clock, design and requester
  // ****************************************
  initial forever #2.5 core_clk = ~core_clk;
  ioic_top ioic_top_inst (.CORE_CLK(core_clk), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat_i),
    .WB_DAT_O(dat_o), .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_ACK_O(ack), .EXT_IRQ(ext_irq), .SERVICE_ACKNOWLEDGE(svc_ack),
    .SERIAL_IN_LOADED(ev[0]), .SERIAL_OUT_TAKEN(ev[2]), .SERIAL_DATA_READ(ev[1]),
    .SERIAL_DATA_WRITE(ev[3]), .PAR_IN_WRITTEN(ev[4]), .PAR_OUT_READ(ev[6]),
    .PAR_PORT_A_READ(ev[5]), .PAR_PORT_B_READ(ev[8]), .PAR_PORT_A_WRITE(ev[9]),
    .PAR_PORT_B_WRITE(ev[7]), .INSTR_BOUNDARY(ev[10]), .INSTR_UNINTERRUPTIBLE(unint),
    .TRAP_CALL(trap), .RETURN_EXEC(ev[11]), .JAM_BRANCH(jam), .JAM_TARGET(target),
    .PC_SHADOW_EN(shadow), .IRQ_PENDING(pend), .PAR_OUT_STROBE_O(pos_o),
    .PAR_OUT_STROBE_OE(pos_oe), .PAR_IN_STROBE_O(pis_o), .PAR_IN_STROBE_OE(pis_oe));
  ioic_ext_req ioic_ext_req_inst (.clk(core_clk), .rst(rst), .go(ev[12]),
    .hold_len(hold), .irq(ext_irq));
  // Verdict, reached from the main sequence and from any timeout
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One classic cycle; everything holds until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d,
                    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_i <= {16'h0, d};
    @(posedge core_clk);
    while (ack !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 20) begin n_fail++; tally_and_finish(); end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // One-cycle event pulse, then a few quiet cycles
  task automatic pulse(input int k, input int gap);
    @(posedge core_clk);
    ev[k] <= 1'b1;
    @(posedge core_clk);
    ev[k] <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask
  // Offer one instruction boundary; target zero means no entry expected
  task automatic enter(input logic t, input logic u, input logic [15:0] tgt);
    @(posedge core_clk);
    ev[10] <= 1'b1;
    trap <= t;
    unint <= u;
    @(posedge core_clk);
    ev[10] <= 1'b0;
    trap <= 1'b0;
    unint <= 1'b0;
    #1;
    `CHK(jam, tgt != 16'h0)
    `CHK(svc_ack, tgt != 16'h0)
    `CHK(shadow, tgt == 16'h0)
    if (tgt != 16'h0) `CHK(target, tgt)
  endtask
  // Length of one strobe pulse in cycles, bounded both ways
  task automatic count(input logic o, output int c);
    int w;
    w = 0;
    c = 0;
    while ((o ? pos_o : pis_o) !== 1'b1 && w < 10) begin
      @(posedge core_clk);
      w++;
    end
    if (w >= 10) begin n_fail++; tally_and_finish(); end
    while ((o ? pos_o : pis_o) === 1'b1 && c < 20) begin
      @(posedge core_clk);
      c++;
    end
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK(shadow, 1'b1)
    wb(1'b0, CTRL_ADDR, 16'h0, 4'hf);
    `CHK(q[15:0], 16'h0000)
    wb(1'b0, 4'hc, 16'h0, 4'hf);
    `CHK(q, 32'h0)
    wb(1'b1, CTRL_ADDR, 16'hffff, 4'h1);
    wb(1'b0, CTRL_ADDR, 16'h0, 4'hf);
    `CHK(q[15:0], 16'h00e0)
    wb(1'b1, CTRL_ADDR, 16'hfbff, 4'h3);
    wb(1'b0, CTRL_ADDR, 16'h0, 4'hf);
    `CHK(q[15:0], 16'h7be0)
    wb(1'b1, CFG_ADDR, 16'h0001, 4'h1);
    wb(1'b0, CFG_ADDR, 16'h0, 4'hf);
    `CHK(q, 32'h1)
    wb(1'b0, CTRL_ADDR, 16'h0, 4'hf);
    `CHK(q[15:0], 16'h7fe0)
    $display("test registers done");
    // Each internal flag: set, survive a write, clear by its own event
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, CTRL_ADDR, 16'h0000, 4'h3);
      pulse(set_ev[i], 1);
      `CHK(pend, 1'b0)
      wb(1'b1, CTRL_ADDR, 16'h0000, 4'h3);
      wb(1'b0, CTRL_ADDR, 16'h0, 4'hf);
      `CHK(q[15:0], exp_v[i])
      pulse(clr_ev[i], 1);
      wb(1'b0, CTRL_ADDR, 16'h0, 4'hf);
      `CHK(q[15:0], 16'h0000)
    end
    $display("test flags done");
    wb(1'b1, CTRL_ADDR, 16'h0200, 4'h3);
    pulse(0, 1);
    `CHK(pend, 1'b1)
    enter(1'b0, 1'b1, 16'h0);
    enter(1'b0, 1'b0, HW_VECTOR);
    wb(1'b0, SEQ_ADDR, 16'h0, 4'hf);
    `CHK(q, 32'h00010006)
    pulse(11, 2);
    `CHK(svc_ack, 1'b0)
    enter(1'b0, 1'b0, HW_VECTOR);
    pulse(11, 2);
    pulse(1, 1);
    `CHK(pend, 1'b0)
    enter(1'b0, 1'b0, 16'h0);
    $display("test entry done");
    wb(1'b1, CTRL_ADDR, 16'h0020, 4'h3);
    enter(1'b1, 1'b0, TRAP_VECTOR);
    pulse(12, 8);
    wb(1'b0, CTRL_ADDR, 16'h0, 4'hf);
    `CHK(q[4:0], 5'h00)
    pulse(11, 2);
    hold <= 4'h6;
    pulse(12, 8);
    `CHK(pend, 1'b1)
    enter(1'b0, 1'b0, HW_VECTOR);
    pulse(11, 3);
    wb(1'b0, CTRL_ADDR, 16'h0, 4'hf);
    `CHK(q[4:0], 5'h00)
    $display("test external done");
    // Every width code on both strobes in active mode
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, CTRL_ADDR, {1'b0, c[1:0], 13'h1800}, 4'h3);
      pulse(9, 0);
      count(1'b1, n);
      `CHK(n, (c + 1) * T_CYCLES)
      `CHK(pos_oe, 1'b1)
      pulse(5, 0);
      count(1'b0, n);
      `CHK(n, (c + 1) * T_CYCLES)
      `CHK(pis_oe, 1'b1)
    end
    wb(1'b1, CTRL_ADDR, 16'h0000, 4'h3);
    pulse(9, 1);
    `CHK({pos_oe, pis_oe}, 2'b00)
    $display("test strobes done");
    // Mid-run reset with enables and a flag set must clear both
    wb(1'b1, CTRL_ADDR, 16'h03e0, 4'h3);
    pulse(0, 0);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    wb(1'b0, CTRL_ADDR, 16'h0, 4'hf);
    `CHK(q[15:0], 16'h0000)
    `CHK(shadow, 1'b1)
    $display("test reset done");
    tally_and_finish();
  end
endmodule
